/* core/ugc_pkg.sv */
/*
  Package for the USB general control block: register byte offsets, field
  positions, reset values and the endpoint memory layout.
  Assumes an AXI4-Lite master with 32-bit data and one register per word.
*/
package ugc_pkg;
  localparam int NUM_EP = 7;
  localparam int EP_SRC = 8;
  localparam int MEM_W = 10;
  // register byte offsets
  localparam logic [7:0] OFF_PAD = 8'h00;
  localparam logic [7:0] OFF_GCTL = 8'h04;
  localparam logic [7:0] OFF_GSTA = 8'h08;
  localparam logic [7:0] OFF_GIRQ = 8'h0C;
  localparam logic [7:0] OFF_DCTL = 8'h10;
  localparam logic [7:0] OFF_DIRQ = 8'h14;
  localparam logic [7:0] OFF_DIEN = 8'h18;
  localparam logic [7:0] OFF_EPSUM = 8'h1C;
  localparam logic [7:0] OFF_EPSEL = 8'h20;
  localparam logic [7:0] OFF_EPCFG = 8'h24;
  localparam logic [7:0] OFF_EPFLG = 8'h28;
  localparam logic [7:0] OFF_EPIEN = 8'h2C;
  localparam logic [7:0] OFF_EPBASE = 8'h30;
  // general control fields
  localparam int GC_EN = 7;
  localparam int GC_FRZ = 5;
  localparam int GC_PADE = 4;
  localparam int GC_VTE = 0;
  localparam logic [7:0] GCTL_RST = 8'h20;
  localparam logic [7:0] GCTL_MASK = 8'hB1;
  // status fields
  localparam int GS_ROLE = 1;
  localparam int GS_SUPPLY_PRESENT_FLAG = 0;
  // device control fields
  localparam int DC_DETACH = 0;
  localparam int DC_LSM = 2;
  localparam int DC_RSTCPU = 3;
  localparam logic [7:0] DCTL_RST = 8'h01;
  localparam logic [7:0] DCTL_MASK = 8'h0D;
  // device irq fields
  localparam int DI_SUSP = 0;
  localparam int DI_WAKE = 4;
  localparam logic [7:0] DI_MASK = 8'h11;
  // endpoint config fields and AXI response codes
  localparam int EC_EN = 0;
  localparam int EC_MEMORY_RESERVE_BIT = 1;
  localparam int EC_BK = 2;
  localparam int EC_SZ = 4;
  localparam int EC_OK = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* core/ugc_general_control.sv */
/*
  USB device general control: enable/reset, clock freeze, pad idle control,
  supply detection, wake detection, interrupt lines and sliding endpoint
  memory allocation, behind an AXI4-Lite register slave.
  Assumes supply and data-line activity inputs are asynchronous to aclk and are synchronised here;
  bus suspend and endpoint source events come from the transfer engine.
*/
`timescale 1ns/100ps
// Function
// RULE1: hardware resets leave controller disabled, reset
// RULE2: bus end-of-reset CPU reset keeps controller enabled
// RULE3: reset state: disabled, frozen, pad suspended
// RULE4: enable enters idle; disable resets controller
// RULE5: separate general and endpoint interrupt lines
// RULE6: supply and wake detection work while frozen
// RULE7: every data-line change raises wake flag; code raises it only while the controller is enabled
// RULE8: eight enabled endpoint sources; summary shows endpoint
// RULE9: power-down wakes only on wake, supply
// RULE10: general and device registers accessible while frozen
// RULE11: frozen clock permits only wake, supply interrupts
// RULE12: low speed select routes pull-up D- or D+
// RULE13: firmware reserves endpoint memory in increasing order
// RULE14: reserve inserts buffer, next endpoint slides up
// RULE15: disable keeps reservation; free slides next down
// RULE16: endpoint 0 kept; same parameters no slide
// RULE17: config accepted even when memory overlaps
// RULE18: suspend idles pad; non-idle wakes pad
// RULE19: detach idles pad; clearing detach reactivates
// RULE20: supply present at 1.4V; role reads one
// RULE21: every supply edge sets flag; enable gates
// RULE22: no attach without supply; pad enable always writable
// RULE23: async detections synchronised before setting flags
module ugc_general_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic session_valid,
  input wire logic line_activity,
  input wire logic bus_suspend,
  input wire logic bus_end_of_reset,
  input wire logic [6:0] ep_events,
  input wire logic [2:0] ep_event_src,
  output logic ctrl_reset,
  output logic ctrl_clk_en,
  output logic xcvr_en,
  output logic pad_active,
  output logic pullup_dplus,
  output logic pullup_dminus,
  output logic pad_regulator_enable,
  output logic supply_sense_pad_enable,
  output logic cpu_reset_req,
  output logic general_irq,
  output logic endpoint_irq
);
  logic [7:0] pad_r, gctl_r, dctl_r, dirq_r, dien_r, epsel_r;
  logic [7:0] epcfg_r [ugc_pkg::NUM_EP];
  logic [7:0] epflg_r [ugc_pkg::NUM_EP];
  logic [7:0] epien_r [ugc_pkg::NUM_EP];
  logic [ugc_pkg::MEM_W-1:0] base_r [ugc_pkg::NUM_EP];
  logic vtrans_r;
  logic sv_s1_r, sv_s2_r, sv_s3_r, la_s1_r, la_s2_r, la_s3_r;
  logic aw_hold_r, w_hold_r, wstrb_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wr_go, rd_go, bad_wr_nxt;
  logic [7:0] wa, wd;
  logic [2:0] sel;
  logic en, frozen, supply_edge, wake_ev, susp_ev;
  logic [7:0] ep_sum;
  logic [7:0] rd_nxt;

  assign en = gctl_r[ugc_pkg::GC_EN];
  assign frozen = gctl_r[ugc_pkg::GC_FRZ] | ~en;
  assign sel = epsel_r[2:0] < 3'h7 ? epsel_r[2:0] : 3'h0;

  // aw and w accepted in either order, response after both
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = (aw_hold_r | (s_axi_awvalid & s_axi_awready)) &
                 (w_hold_r | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign wa = aw_hold_r ? awaddr_r : s_axi_awaddr[7:0];
  assign wd = w_hold_r ? wdata_r[7:0] : s_axi_wdata[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr[7:0];
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // byte lane 0 must be strobed; unmapped address answers SLVERR
  logic wstrb0;
  assign wstrb0 = w_hold_r ? wstrb_r : s_axi_wstrb[0];
  assign bad_wr_nxt = (wa > ugc_pkg::OFF_EPBASE) || (wa[1:0] != 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ugc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bad_wr_nxt ? ugc_pkg::RESP_SLVERR : ugc_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = wr_go & wstrb0 & ~bad_wr_nxt;

  // synchronisers for the asynchronous detections
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sv_s1_r <= 1'b0;
      sv_s2_r <= 1'b0;
      sv_s3_r <= 1'b0;
      la_s1_r <= 1'b0;
      la_s2_r <= 1'b0;
      la_s3_r <= 1'b0;
    end else begin
      sv_s1_r <= session_valid; // RULE23
      sv_s2_r <= sv_s1_r;
      sv_s3_r <= sv_s2_r;
      la_s1_r <= line_activity; // RULE23
      la_s2_r <= la_s1_r;
      la_s3_r <= la_s2_r;
    end
  end
  // supply edges need only the pad enable, not the controller clock
  assign supply_edge = gctl_r[ugc_pkg::GC_PADE] & (sv_s2_r ^ sv_s3_r); // RULE6 RULE21
  assign wake_ev = en & (la_s2_r ^ la_s3_r); // RULE6 RULE7
  assign susp_ev = en & ~frozen & bus_suspend; // RULE11

  // general control and pad regulator; any hardware reset disables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gctl_r <= ugc_pkg::GCTL_RST; // RULE1 RULE3
      pad_r <= 8'h00;
    end else if (wr_en && wa == ugc_pkg::OFF_GCTL) begin
      gctl_r <= wd & ugc_pkg::GCTL_MASK; // RULE10 RULE22
    end else if (wr_en && wa == ugc_pkg::OFF_PAD) begin
      pad_r <= {7'h00, wd[0]};
    end
  end

  // device control: detach resets to set
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      dctl_r <= ugc_pkg::DCTL_RST; // RULE4
      dien_r <= 8'h00;
    end else if (wr_en && wa == ugc_pkg::OFF_DCTL) begin
      dctl_r <= wd & ugc_pkg::DCTL_MASK; // RULE10
    end else if (wr_en && wa == ugc_pkg::OFF_DIEN) begin
      dien_r <= wd & ugc_pkg::DI_MASK;
    end
  end

  // suspend and wake flags clear each other; set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      dirq_r <= 8'h00;
    end else if (wake_ev) begin
      dirq_r[ugc_pkg::DI_WAKE] <= 1'b1; // RULE7
      dirq_r[ugc_pkg::DI_SUSP] <= 1'b0;
    end else if (susp_ev) begin
      dirq_r[ugc_pkg::DI_SUSP] <= 1'b1; // RULE18
      dirq_r[ugc_pkg::DI_WAKE] <= 1'b0;
    end else if (wr_en && wa == ugc_pkg::OFF_DIRQ) begin
      dirq_r <= dirq_r & wd & ugc_pkg::DI_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vtrans_r <= 1'b0;
    end else if (supply_edge) begin
      vtrans_r <= 1'b1; // RULE21
    end else if (wr_en && wa == ugc_pkg::OFF_GIRQ && !wd[0]) begin
      vtrans_r <= 1'b0;
    end
  end

  // endpoint select, flags and enables
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      epsel_r <= 8'h00;
    end else if (wr_en && wa == ugc_pkg::OFF_EPSEL) begin
      epsel_r <= {5'h00, wd[2:0]};
    end
  end

  for (genvar i = 0; i < ugc_pkg::NUM_EP; i++) begin : g_ep
    always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
        epflg_r[i] <= 8'h00;
        epien_r[i] <= 8'h00;
      end else begin
        if (ep_events[i] && !frozen) begin
          epflg_r[i][ep_event_src] <= 1'b1; // RULE8 RULE11
        end else if (wr_en && wa == ugc_pkg::OFF_EPFLG && sel == 3'(i)) begin
          epflg_r[i] <= epflg_r[i] & wd;
        end
        if (wr_en && wa == ugc_pkg::OFF_EPIEN && sel == 3'(i)) begin
          epien_r[i] <= wd;
        end
      end
    end
    assign ep_sum[i] = |(epflg_r[i] & epien_r[i]); // RULE8
    frozen_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
      frozen |=> (epflg_r[i] & ~$past(epflg_r[i])) == 8'h00)
      else $error("endpoint event while frozen");
  end
  assign ep_sum[7] = 1'b0;

  // endpoint size in bytes: 8 << size code, times banks
  function automatic logic [ugc_pkg::MEM_W-1:0] ep_bytes(input logic [7:0] c);
    logic [ugc_pkg::MEM_W-1:0] b;
    b = ugc_pkg::MEM_W'(10'd8 << c[6:4]);
    if (c[ugc_pkg::EC_BK]) begin
      b = ugc_pkg::MEM_W'(b << 1);
    end
    ep_bytes = c[ugc_pkg::EC_MEMORY_RESERVE_BIT] ? b : '0;
    return ep_bytes;
  endfunction

  // sliding allocation: only the next endpoint moves
  logic memory_reserve_bit_wr;
  logic [7:0] newcfg;
  logic [ugc_pkg::MEM_W-1:0] ins_base;
  assign memory_reserve_bit_wr = wr_en && wa == ugc_pkg::OFF_EPCFG;
  assign newcfg = {1'b0, wd[6:0]};
  always_comb begin
    ins_base = '0;
    for (int k = 0; k < ugc_pkg::NUM_EP; k++) begin
      if (k < int'(sel) && epcfg_r[k][ugc_pkg::EC_MEMORY_RESERVE_BIT]) begin
        ins_base = base_r[k] + ep_bytes(epcfg_r[k]);
      end
    end
  end

  for (genvar i = 0; i < ugc_pkg::NUM_EP; i++) begin : g_cfg
    localparam int PREV = (i > 0) ? i - 1 : 0;
    always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
        epcfg_r[i] <= 8'h00;
        base_r[i] <= '0;
      end else if (memory_reserve_bit_wr && sel == 3'(i)) begin
        // config kept when only enable changes
        epcfg_r[i] <= newcfg; // RULE15
        if (newcfg[ugc_pkg::EC_EN] && newcfg[ugc_pkg::EC_MEMORY_RESERVE_BIT]) begin
          epcfg_r[i][ugc_pkg::EC_OK] <= 1'b1; // RULE17
        end
        base_r[i] <= ins_base; // RULE14
      end else if (memory_reserve_bit_wr && i > 0 && sel == 3'(PREV) &&
                   newcfg[6:1] != epcfg_r[PREV][6:1]) begin
        // next endpoint slides by the new end; unchanged params no slide
        base_r[i] <= ins_base + ep_bytes(newcfg); // RULE14 RULE15 RULE16
      end
    end
  end

  // outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_reset_req <= 1'b0;
    end else begin
      cpu_reset_req <= en & dctl_r[ugc_pkg::DC_RSTCPU] & bus_end_of_reset; // RULE2
    end
  end
  logic attach;
  assign attach = en & ~dctl_r[ugc_pkg::DC_DETACH] & sv_s2_r; // RULE22
  assign ctrl_reset = ~aresetn | ~en; // RULE1 RULE4
  assign ctrl_clk_en = en & ~gctl_r[ugc_pkg::GC_FRZ]; // RULE3 RULE4
  assign xcvr_en = en; // RULE4
  assign pad_active = attach & ~dirq_r[ugc_pkg::DI_SUSP]; // RULE18 RULE19
  assign pullup_dminus = attach & dctl_r[ugc_pkg::DC_LSM]; // RULE12
  assign pullup_dplus = attach & ~dctl_r[ugc_pkg::DC_LSM]; // RULE12
  assign pad_regulator_enable = pad_r[0];
  assign supply_sense_pad_enable = gctl_r[ugc_pkg::GC_PADE]; // RULE22
  assign general_irq = (vtrans_r & gctl_r[ugc_pkg::GC_VTE]) |
                       (|(dirq_r & dien_r)); // RULE5 RULE9 RULE21
  assign endpoint_irq = |ep_sum; // RULE5

  // read mux
  always_comb begin
    rd_nxt = 8'h00;
    if (s_axi_araddr[7:0] == ugc_pkg::OFF_PAD) begin
      rd_nxt = pad_r;
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_GCTL) begin
      rd_nxt = gctl_r;
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_GSTA) begin
      rd_nxt = {6'h00, 1'b1, sv_s2_r}; // RULE20
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_GIRQ) begin
      rd_nxt = {7'h00, vtrans_r};
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_DCTL) begin
      rd_nxt = dctl_r;
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_DIRQ) begin
      rd_nxt = dirq_r;
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_DIEN) begin
      rd_nxt = dien_r;
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_EPSUM) begin
      rd_nxt = ep_sum; // RULE8
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_EPSEL) begin
      rd_nxt = epsel_r;
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_EPCFG) begin
      rd_nxt = epcfg_r[sel];
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_EPFLG) begin
      rd_nxt = epflg_r[sel];
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_EPIEN) begin
      rd_nxt = epien_r[sel];
    end else if (s_axi_araddr[7:0] == ugc_pkg::OFF_EPBASE) begin
      rd_nxt = base_r[sel][ugc_pkg::MEM_W-1:2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ugc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_nxt};
      s_axi_rresp <= (s_axi_araddr[7:0] > ugc_pkg::OFF_EPBASE ||
                      s_axi_araddr[1:0] != 2'b00) ?
                     ugc_pkg::RESP_SLVERR : ugc_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  reset_state_a: assert property (@(posedge aclk) $rose(aresetn) |-> // RULE3
    ctrl_reset && !ctrl_clk_en && !xcvr_en && !pad_active && gctl_r == ugc_pkg::GCTL_RST)
    else $error("controller not idle after reset");
  disable_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    !en |-> ctrl_reset && !xcvr_en && !ctrl_clk_en)
    else $error("disabled controller still running");
  speed_pullup_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
    !(pullup_dplus && pullup_dminus) && (!pullup_dminus || dctl_r[ugc_pkg::DC_LSM]))
    else $error("pull-up routing wrong");
  no_attach_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE22
    !sv_s2_r |-> !pullup_dplus && !pullup_dminus)
    else $error("attached without supply");
  supply_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
    ($changed(sv_s2_r) && gctl_r[ugc_pkg::GC_PADE]) |=> vtrans_r)
    else $error("supply edge missed");
  wake_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
    (en && $changed(la_s2_r)) ##1 en |-> dirq_r[ugc_pkg::DI_WAKE])
    else $error("wake event missed");
  detach_pad_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
    dctl_r[ugc_pkg::DC_DETACH] |-> !pad_active)
    else $error("pad active while detached");
  ep_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    endpoint_irq == (|ep_sum[6:0]) && (!endpoint_irq || $past(en)))
    else $error("endpoint interrupt wrong");
endmodule

/* tb/ugc_host_model.sv */
/*
  Bus-side stand-in for the host and transfer engine: supply level,
  data-line activity bursts, suspend and end-of-reset pulses.
  Assumes bench requests arrive as one-cycle pulses on aclk.
*/
`timescale 1ns/100ps
module ugc_host_model (
  input wire logic aclk,
  input wire logic supply_present_flag_on,
  input wire logic slow,
  input wire logic suspend_go,
  input wire logic resume_go,
  input wire logic reset_go,
  output logic session_valid,
  output logic line_activity,
  output logic bus_suspend,
  output logic bus_end_of_reset
);
  logic [2:0] susp_r;
  logic [2:0] res_r;
  initial begin
    susp_r = 3'h0;
    res_r = 3'h0;
    session_valid = 1'b0;
    line_activity = 1'b0;
    bus_suspend = 1'b0;
    bus_end_of_reset = 1'b0;
  end
  always @(posedge aclk) begin
    session_valid <= supply_present_flag_on;
    bus_end_of_reset <= reset_go;
    bus_suspend <= (susp_r != 3'h0);
    // slow host holds suspend for three cycles
    if (suspend_go) susp_r <= slow ? 3'h3 : 3'h1;
    else if (susp_r != 3'h0) susp_r <= susp_r - 3'h1;
    if (resume_go) res_r <= 3'h5;
    else if (res_r != 3'h0) res_r <= res_r - 3'h1;
    // data lines toggle only during a burst, still otherwise
    if (res_r != 3'h0) line_activity <= ~line_activity;
  end
endmodule

/* tb/testbench.sv */
/*
  Self-checking bench for the general control block: register model,
  pin model and endpoint memory model compared against the design.
  Assumes the host model drives the bus-side inputs.
*/
`timescale 1ns/100ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic session_valid, line_activity, bus_suspend, bus_end_of_reset;
  logic [6:0] ep_events = 7'h00;
  logic [2:0] ep_event_src = 3'h0;
  logic ctrl_reset, ctrl_clk_en, xcvr_en, pad_active, pullup_dplus, pullup_dminus;
  logic pad_regulator_enable, supply_sense_pad_enable, cpu_reset_req, general_irq, endpoint_irq;
  logic supply_present_flag_on = 1'b0, slow = 1'b0, susp_go = 1'b0, res_go = 1'b0, rst_go = 1'b0;
  logic [31:0] seed = 32'h99B7A269, d;
  logic [1:0] r;
  logic [7:0] m_gctl, m_dctl, dv[4];
  logic m_sv = 1'b0, m_susp = 1'b0, m_pad = 1'b0;
  int mismatches = 0, n_tests = 0, n_cpu = 0, sz[3], base, k, src;

  ugc_general_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .session_valid(session_valid), .line_activity(line_activity),
    .bus_suspend(bus_suspend), .bus_end_of_reset(bus_end_of_reset), .ep_events(ep_events),
    .ep_event_src(ep_event_src), .ctrl_reset(ctrl_reset), .ctrl_clk_en(ctrl_clk_en),
    .xcvr_en(xcvr_en), .pad_active(pad_active), .pullup_dplus(pullup_dplus),
    .pullup_dminus(pullup_dminus), .pad_regulator_enable(pad_regulator_enable),
    .supply_sense_pad_enable(supply_sense_pad_enable), .cpu_reset_req(cpu_reset_req),
    .general_irq(general_irq), .endpoint_irq(endpoint_irq));

  ugc_host_model i_host (.aclk(aclk), .supply_present_flag_on(supply_present_flag_on), .slow(slow), .suspend_go(susp_go),
    .resume_go(res_go), .reset_go(rst_go), .session_valid(session_valid),
    .line_activity(line_activity), .bus_suspend(bus_suspend),
    .bus_end_of_reset(bus_end_of_reset));

  always #50 aclk = ~aclk;
  always @(posedge aclk) if (cpu_reset_req === 1'b1) n_cpu++;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic give_verdict;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        chk({30'h0, s_axi_bresp}, {30'h0, ugc_pkg::RESP_OKAY});
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // read, mask and compare one register
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rr;
    rd(a, v, rr);
    chk(v & m, e);
  endtask

  task automatic chk_pins;
    logic en, att;
    en = m_gctl[7];
    att = en & ~m_dctl[0] & m_sv;
    chk({24'h0, ctrl_reset, ctrl_clk_en, xcvr_en, pad_active, pullup_dplus, pullup_dminus,
      supply_sense_pad_enable, pad_regulator_enable}, {24'h0, ~en, en & ~m_gctl[5], en,
      att & ~m_susp, att & ~m_dctl[2], att & m_dctl[2], m_gctl[4], m_pad});
  endtask

  // one-cycle request to the host model: bit0 suspend, bit1 resume, bit2 bus reset
  task automatic pulse(input logic [2:0] w);
    @(posedge aclk);
    {rst_go, res_go, susp_go} <= w;
    @(posedge aclk);
    {rst_go, res_go, susp_go} <= 3'h0;
    idle(8);
  endtask

  task automatic supply_present_flag(input logic v);
    @(posedge aclk);
    supply_present_flag_on <= v;
    idle(6);
    m_sv = v;
  endtask

  task automatic ep_pulse(input int e, input int s);
    @(posedge aclk);
    ep_events <= 7'h01 << e;
    ep_event_src <= s[2:0];
    @(posedge aclk);
    ep_events <= 7'h00;
    idle(2);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    m_gctl = ugc_pkg::GCTL_RST;
    m_dctl = ugc_pkg::DCTL_RST;
    dv = '{8'h00, 8'h04, 8'h05, 8'h00};
    idle(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_pins();
    rc(ugc_pkg::OFF_GCTL, 32'hFF, 32'h20);
    rc(ugc_pkg::OFF_DCTL, 32'hFF, 32'h01);
    rc(ugc_pkg::OFF_GSTA, 32'hFF, 32'h02);
    rd(8'h34, d, r);
    chk({30'h0, r}, {30'h0, ugc_pkg::RESP_SLVERR});
    wr(ugc_pkg::OFF_PAD, 8'h01);
    m_pad = 1'b1;
    wr(ugc_pkg::OFF_GCTL, 8'h31);
    m_gctl = 8'h31;
    chk_pins();
    supply_present_flag(1'b1);
    rc(ugc_pkg::OFF_GSTA, 32'hFF, 32'h03);
    rc(ugc_pkg::OFF_GIRQ, 32'hFF, 32'h01);
    chk(general_irq, 1);
    wr(ugc_pkg::OFF_GIRQ, 8'h00);
    chk(general_irq, 0);
    wr(ugc_pkg::OFF_GCTL, 8'h30);
    supply_present_flag(1'b0);
    rc(ugc_pkg::OFF_GIRQ, 32'hFF, 32'h01);
    chk(general_irq, 0);
    supply_present_flag(1'b1);
    wr(ugc_pkg::OFF_GIRQ, 8'h00);
    wr(ugc_pkg::OFF_GCTL, 8'h90);
    m_gctl = 8'h90;
    chk_pins();
    for (k = 0; k < 4; k++) begin
      wr(ugc_pkg::OFF_DCTL, dv[k]);
      m_dctl = dv[k];
      chk_pins();
    end
    supply_present_flag(1'b0);
    chk_pins();
    supply_present_flag(1'b1);
    wr(ugc_pkg::OFF_GIRQ, 8'h00);
    // endpoint memory: three buffers in increasing order
    base = 0;
    for (k = 0; k < 3; k++) begin
      sz[k] = int'(rnd() & 32'h3);
      wr(ugc_pkg::OFF_EPSEL, k[7:0]);
      wr(ugc_pkg::OFF_EPCFG, 8'(sz[k] << 4) | 8'h03);
      rc(ugc_pkg::OFF_EPCFG, 32'hFF, 32'(sz[k] << 4) | 32'h83);
      rc(ugc_pkg::OFF_EPBASE, 32'hFF, 32'(base / 4));
      base = base + (8 << sz[k]);
    end
    wr(ugc_pkg::OFF_EPSEL, 8'h01);
    wr(ugc_pkg::OFF_EPCFG, 8'(sz[1] << 4) | 8'h02);
    rc(ugc_pkg::OFF_EPCFG, 32'h7F, 32'(sz[1] << 4) | 32'h02);
    wr(ugc_pkg::OFF_EPSEL, 8'h02);
    rc(ugc_pkg::OFF_EPBASE, 32'hFF, 32'(((8 << sz[0]) + (8 << sz[1])) / 4));
    wr(ugc_pkg::OFF_EPSEL, 8'h01);
    wr(ugc_pkg::OFF_EPCFG, 8'(sz[1] << 4));
    wr(ugc_pkg::OFF_EPSEL, 8'h02);
    rc(ugc_pkg::OFF_EPBASE, 32'hFF, 32'((8 << sz[0]) / 4));
    wr(ugc_pkg::OFF_EPSEL, 8'h01);
    wr(ugc_pkg::OFF_EPCFG, 8'h43);
    wr(ugc_pkg::OFF_EPSEL, 8'h02);
    rc(ugc_pkg::OFF_EPBASE, 32'hFF, 32'(((8 << sz[0]) + 128) / 4));
    wr(ugc_pkg::OFF_EPSEL, 8'h00);
    rc(ugc_pkg::OFF_EPBASE, 32'hFF, 32'h0);
    // endpoint interrupt through a random source
    wr(ugc_pkg::OFF_EPSEL, 8'h02);
    wr(ugc_pkg::OFF_EPIEN, 8'hFF);
    src = int'(rnd() & 32'h7);
    ep_pulse(2, src);
    chk(endpoint_irq, 1);
    chk(general_irq, 0);
    rc(ugc_pkg::OFF_EPSUM, 32'hFF, 32'h04);
    rc(ugc_pkg::OFF_EPFLG, 32'hFF, 32'h1 << src);
    wr(ugc_pkg::OFF_EPFLG, 8'h00);
    chk(endpoint_irq, 0);
    wr(ugc_pkg::OFF_EPIEN, ~(8'h01 << src));
    ep_pulse(2, src);
    chk(endpoint_irq, 0);
    wr(ugc_pkg::OFF_EPFLG, 8'h00);
    wr(ugc_pkg::OFF_EPIEN, 8'hFF);
    // suspend, freeze, wake while frozen
    slow <= 1'b1;
    pulse(3'h1);
    m_susp = 1'b1;
    rc(ugc_pkg::OFF_DIRQ, 32'h01, 32'h01);
    chk_pins();
    wr(ugc_pkg::OFF_GCTL, 8'hB0);
    m_gctl = 8'hB0;
    chk_pins();
    rc(ugc_pkg::OFF_GCTL, 32'hFF, 32'hB0);
    wr(ugc_pkg::OFF_DCTL, 8'h04);
    m_dctl = 8'h04;
    rc(ugc_pkg::OFF_DCTL, 32'hFF, 32'h04);
    ep_pulse(2, src);
    chk(endpoint_irq, 0);
    wr(ugc_pkg::OFF_DIEN, 8'h10);
    chk(general_irq, 0);
    pulse(3'h2);
    m_susp = 1'b0;
    rc(ugc_pkg::OFF_DIRQ, 32'h10, 32'h10);
    chk(general_irq, 1);
    chk_pins();
    wr(ugc_pkg::OFF_GCTL, 8'h90);
    wr(ugc_pkg::OFF_DCTL, 8'h08);
    pulse(3'h4);
    chk(n_cpu, 1);
    chk({ctrl_reset, xcvr_en}, 2'b01);
    wr(ugc_pkg::OFF_GCTL, 8'h10);
    m_gctl = 8'h10;
    m_dctl = ugc_pkg::DCTL_RST;
    rc(ugc_pkg::OFF_DCTL, 32'hFF, 32'h01);
    chk_pins();
    give_verdict();
  end
endmodule
